/* verilog/digital_watchdog_timers.v */
// Purpose: Three digital watchdogs with AXI4-Lite registers, interrupt and reset requests.
// Assumes: Single 200 MHz clock; flash_boot is a level valid when rst is released.
// Notes: Watchdogs 0 and 1 are the main watchdogs, 2 is the always-on watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module digital_watchdog_timers #(
	parameter BOOT_TIMEOUT = `WDT_BOOT_TIMEOUT_CYCLES
) (
	input wire clock,               // System clock
	input wire rst,                 // Synchronous reset, active high
	input wire flash_boot,          // Device is booting from flash
	input wire [7:0] s_axi_awaddr,  // Write address
	input wire s_axi_awvalid,       // Write address valid
	output reg s_axi_awready,       // Write address ready
	input wire [31:0] s_axi_wdata,  // Write data
	input wire [3:0] s_axi_wstrb,   // Write byte strobes
	input wire s_axi_wvalid,        // Write data valid
	output reg s_axi_wready,        // Write data ready
	output reg [1:0] s_axi_bresp,   // Write response
	output reg s_axi_bvalid,        // Write response valid
	input wire s_axi_bready,        // Write response ready
	input wire [7:0] s_axi_araddr,  // Read address
	input wire s_axi_arvalid,       // Read address valid
	output reg s_axi_arready,       // Read address ready
	output reg [31:0] s_axi_rdata,  // Read data
	output reg [1:0] s_axi_rresp,   // Read response
	output reg s_axi_rvalid,        // Read data valid
	input wire s_axi_rready,        // Read data ready
	output reg irq,                 // Level interrupt
	output reg cpu_reset_req,       // Processor reset pulse
	output reg core_reset_req,      // Core reset pulse
	output reg system_reset_req     // System reset pulse
);

	localparam NWD = 3;
	localparam AON = 2;
	localparam [31:0] BOOT_TMO = BOOT_TIMEOUT;

	reg [31:0] cfg [0:NWD-1];
	reg [31:0] tmo [0:4*NWD-1];
	reg [NWD-1:0] locked;
	reg [NWD-1:0] feed;
	reg [NWD-1:0] int_raw;
	reg [NWD-1:0] int_ena;
	reg boot_arm;
	reg boot_seen;
	reg [7:0] wa;
	reg [31:0] wd;
	reg [3:0] ws;
	reg [7:0] ra;
	reg [31:0] next_rdata;
	reg next_rerr;
	reg next_werr;
	reg [NWD-1:0] next_int_set;
	reg next_cpu;
	reg next_core;
	reg next_sys;
	integer i;

	wire [NWD-1:0] expire;
	wire [2*NWD-1:0] exp_stage;
	wire [2*NWD-1:0] cur_stage;
	wire [32*NWD-1:0] cur_count;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (st[b]) begin
					merge[b*8 +: 8] = nw[b*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Watchdog instances
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NWD; g = g + 1) begin : wdt
			wdt_stage_timer #(
				.CW(32)
			) u_timer (
				.clock(clock),
				.rst(rst),
				.enable(cfg[g][`WDT_CFG_ENABLE]),
				.stage_en(cfg[g][`WDT_CFG_STAGE_EN_LSB +: 4]),
				.timeouts({tmo[4*g+3], tmo[4*g+2], tmo[4*g+1], tmo[4*g]}),
				.feed(feed[g]),
				.expire(expire[g]),
				.expire_stage(exp_stage[2*g +: 2]),
				.stage(cur_stage[2*g +: 2]),
				.count(cur_count[32*g +: 32])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Stage actions
	// ----------------------------------------------------------------
	wire [NWD-1:0] dec_irq;
	wire [NWD-1:0] dec_cpu;
	wire [NWD-1:0] dec_core;
	wire [NWD-1:0] dec_sys;

	generate
		for (g = 0; g < NWD; g = g + 1) begin : dec
			wdt_action_decode #(
				.ALLOW_SYSTEM(g == AON)
			) u_decode (
				.expire(expire[g]),
				.action(cfg[g][`WDT_CFG_ACTION_LSB + 3*exp_stage[2*g +: 2] +: 3]),
				.set_irq(dec_irq[g]),
				.cpu(dec_cpu[g]),
				.core(dec_core[g]),
				.sys(dec_sys[g])
			);
		end
	endgenerate

	// Requests of all watchdogs merge onto the shared reset outputs
	always @* begin
		next_int_set = dec_irq;
		next_cpu = |dec_cpu;
		next_core = |dec_core;
		next_sys = |dec_sys;
	end

	always @(posedge clock) begin
		if (rst) begin
			cpu_reset_req <= 1'b0;
			core_reset_req <= 1'b0;
			system_reset_req <= 1'b0;
			irq <= 1'b0;
		end else begin
			cpu_reset_req <= next_cpu;
			core_reset_req <= next_core;
			system_reset_req <= next_sys;
			irq <= |(int_raw & int_ena);
		end
	end

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	wire [1:0] wblk = wa[7:6];
	wire [3:0] woff = wa[5:2];

	always @* begin
		next_werr = 1'b1;
		if (wblk == `WDT_GLOBAL_BLOCK) begin
			if (woff == `WDT_INT_RAW || woff == `WDT_INT_ENABLE) begin
				next_werr = 1'b0;
			end
		end else if (woff <= `WDT_BLOCK_PROTECT) begin
			next_werr = 1'b0;
		end
	end

	always @(posedge clock) begin
		feed <= {NWD{1'b0}};
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wa <= 8'h00;
			wd <= 32'h00000000;
			ws <= 4'h0;
			locked <= {NWD{1'b1}};
			int_ena <= {NWD{1'b0}};
			int_raw <= {NWD{1'b0}};
			boot_arm <= 1'b1;
			boot_seen <= 1'b0;
			for (i = 0; i < NWD; i = i + 1) begin
				cfg[i] <= 32'h00000000;
			end
			for (i = 0; i < 4*NWD; i = i + 1) begin
				tmo[i] <= 32'h00000000;
			end
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			boot_arm <= 1'b0;
			if (wr_go) begin
				wa <= s_axi_awaddr;
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Sticky interrupt bits: a new event beats a write-one clear
			int_raw <= int_raw | next_int_set;
			if (boot_arm && flash_boot) begin
				boot_seen <= 1'b1;
				cfg[0] <= `WDT_BOOT_CFG_MAIN;
				tmo[0] <= BOOT_TMO;
				cfg[AON] <= `WDT_BOOT_CFG_AON;
				tmo[4*AON] <= BOOT_TMO;
			end
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= next_werr ? 2'h2 : 2'h0;
				if (wblk == `WDT_GLOBAL_BLOCK) begin
					if (woff == `WDT_INT_RAW) begin
						int_raw <= (int_raw & ~(wd[NWD-1:0] & {NWD{ws[0]}})) | next_int_set;
					end else if (woff == `WDT_INT_ENABLE && ws[0]) begin
						int_ena <= wd[NWD-1:0];
					end
				end else if (woff == `WDT_BLOCK_FEED) begin
					feed[wblk] <= 1'b1;
				end else if (woff == `WDT_BLOCK_PROTECT) begin
					locked[wblk] <= (merge(32'h00000000, wd, ws) != `WDT_UNLOCK_KEY);
				end else if (!locked[wblk]) begin
					if (woff == `WDT_BLOCK_CONFIG) begin
						cfg[wblk] <= merge(cfg[wblk], wd, ws) & `WDT_CFG_MASK;
					end else if (woff >= `WDT_BLOCK_STAGE0 && woff <= `WDT_BLOCK_STAGE3) begin
						tmo[4*wblk + woff - 1] <= merge(tmo[4*wblk + woff - 1], wd, ws);
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	wire [1:0] rblk = ra[7:6];
	wire [3:0] roff = ra[5:2];

	always @* begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		if (rblk == `WDT_GLOBAL_BLOCK) begin
			if (roff == `WDT_INT_RAW) begin
				next_rdata[NWD-1:0] = int_raw;
			end else if (roff == `WDT_INT_ENABLE) begin
				next_rdata[NWD-1:0] = int_ena;
			end else if (roff == `WDT_BOOT_STATUS) begin
				next_rdata[0] = boot_seen;
			end else begin
				next_rerr = 1'b1;
			end
		end else if (roff == `WDT_BLOCK_CONFIG) begin
			next_rdata = cfg[rblk];
		end else if (roff >= `WDT_BLOCK_STAGE0 && roff <= `WDT_BLOCK_STAGE3) begin
			next_rdata = tmo[4*rblk + roff - 1];
		end else if (roff == `WDT_BLOCK_FEED) begin
			next_rdata = 32'h00000000;
		end else if (roff == `WDT_BLOCK_PROTECT) begin
			next_rdata[0] = locked[rblk];
		end else if (roff == `WDT_BLOCK_STATUS) begin
			next_rdata[1:0] = cur_stage[2*rblk +: 2];
			next_rdata[2] = locked[rblk];
		end else if (roff == `WDT_BLOCK_COUNT) begin
			next_rdata = cur_count[32*rblk +: 32];
		end else begin
			next_rerr = 1'b1;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			ra <= 8'h00;
		end else begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				ra <= s_axi_araddr;
			end
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rerr ? 32'h00000000 : next_rdata;
				s_axi_rresp <= next_rerr ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

/* shared/wdt_defs.vh */
// Purpose: Constants for the digital watchdog block: register map, fields, keys, timing.
// Assumes: AXI4-Lite byte addresses, 32-bit data, 200 MHz clock.
// Notes: Blocks of 0x40 bytes per watchdog; the global block follows them.
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets inside a watchdog block
// ----------------------------------------------------------------
`define WDT_BLOCK_CONFIG 4'h0
`define WDT_BLOCK_STAGE0 4'h1
`define WDT_BLOCK_STAGE3 4'h4
`define WDT_BLOCK_FEED 4'h5
`define WDT_BLOCK_PROTECT 4'h6
`define WDT_BLOCK_STATUS 4'h7
`define WDT_BLOCK_COUNT 4'h8
// Block 3 is the global block
`define WDT_GLOBAL_BLOCK 2'h3
`define WDT_INT_RAW 4'h0
`define WDT_INT_ENABLE 4'h1
`define WDT_BOOT_STATUS 4'h2

// ----------------------------------------------------------------
// Config fields and encodings
// ----------------------------------------------------------------
`define WDT_CFG_ENABLE 0
`define WDT_CFG_STAGE_EN_LSB 1
`define WDT_CFG_ACTION_LSB 5
`define WDT_CFG_MASK 32'h0001ffff
`define WDT_ACT_NONE 3'h0
`define WDT_ACT_IRQ 3'h1
`define WDT_ACT_CPU 3'h2
`define WDT_ACT_CORE 3'h3
`define WDT_ACT_SYSTEM 3'h4
`define WDT_UNLOCK_KEY 32'h50d83aa1
// Boot setup: enable, stage 0 only; core reset for main, system reset for always-on
`define WDT_BOOT_CFG_MAIN 32'h00000063
`define WDT_BOOT_CFG_AON 32'h00000083

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_CLOCK_MHZ 200
`define WDT_BOOT_TIMEOUT_MS 1000
`define WDT_BOOT_TIMEOUT_CYCLES (`WDT_BOOT_TIMEOUT_MS * `WDT_CLOCK_MHZ * 1000)

`endif

/* verilog/wdt_stage_timer.v */
// Purpose: One watchdog: four-stage sequencer with a 32-bit expiry counter.
// Assumes: Single clock, synchronous active-high reset.
// Notes: expire is a one-cycle pulse; expire_stage names the stage that ran out.
`timescale 1ns/1ps
`default_nettype none

module wdt_stage_timer #(
	parameter CW = 32
) (
	input wire clock,              // System clock
	input wire rst,                // Synchronous reset
	input wire enable,             // Watchdog enable
	input wire [3:0] stage_en,     // Per-stage enables
	input wire [4*CW-1:0] timeouts, // Stage timeouts, stage 0 in low bits
	input wire feed,               // Feed pulse
	output reg expire,             // Stage expiry pulse
	output reg [1:0] expire_stage, // Stage that expired
	output reg [1:0] stage,        // Current stage
	output reg [CW-1:0] count      // Expiry counter
);

	wire [CW-1:0] limit = timeouts[stage*CW +: CW];
	wire [CW:0] count_inc = {1'b0, count} + {{CW{1'b0}}, 1'b1};

	always @(posedge clock) begin
		expire <= 1'b0;
		if (rst) begin
			stage <= 2'h0;
			count <= {CW{1'b0}};
			expire_stage <= 2'h0;
		end else if (!enable || feed) begin
			stage <= 2'h0;
			count <= {CW{1'b0}};
		end else if (!stage_en[stage]) begin
			stage <= stage + 2'h1;
			count <= {CW{1'b0}};
		end else if (count_inc >= {1'b0, limit}) begin
			expire <= 1'b1;
			expire_stage <= stage;
			stage <= stage + 2'h1;
			count <= {CW{1'b0}};
		end else begin
			count <= count_inc[CW-1:0];
		end
	end

endmodule
`default_nettype wire

/* verilog/wdt_unused_placeholder_note.v */
// Purpose: Decodes the action of one watchdog's expired stage into requests.
// Assumes: action is the 3-bit field of the stage that has just run out.
// Notes: System reset is honoured only where ALLOW_SYSTEM is set.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module wdt_action_decode #(
	parameter ALLOW_SYSTEM = 0
) (
	input wire expire, // Stage expiry pulse
	input wire [2:0] action, // Action code of the expired stage
	output reg set_irq, // Set the sticky interrupt bit
	output reg cpu, // Processor reset request
	output reg core, // Core reset request
	output reg sys // System reset request
);

	always @* begin
		set_irq = 1'b0;
		cpu = 1'b0;
		core = 1'b0;
		sys = 1'b0;
		if (expire) begin
			if (action == `WDT_ACT_IRQ) begin
				set_irq = 1'b1;
			end else if (action == `WDT_ACT_CPU) begin
				cpu = 1'b1;
			end else if (action == `WDT_ACT_CORE) begin
				core = 1'b1;
			end else if (action == `WDT_ACT_SYSTEM && ALLOW_SYSTEM != 0) begin
				sys = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

/* bench/digital_watchdog_timers_properties.sv */
// Purpose: Port-level properties of the watchdog block.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Bound from the testbench top file; BOOT_TIMEOUT follows the design.
`timescale 1ns/1ps
`default_nettype none
module digital_watchdog_timers_properties #(
	parameter int BOOT_TIMEOUT = 50
) (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic flash_boot, // Boot mode
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B resp
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic [1:0] s_axi_rresp, // R resp
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic irq, // Interrupt
	input wire logic cpu_reset_req, // CPU reset
	input wire logic core_reset_req, // Core reset
	input wire logic system_reset_req // System reset
);
	localparam int BOOT_MAX = BOOT_TIMEOUT + 8;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	AST_WR_PAIR: assert property (s_axi_awready |-> s_axi_wready && $past(s_axi_awvalid && s_axi_wvalid))
		else $error("write taken without both valids");
	AST_WR_RESP: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_RD_RESP: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_CAUSE: assert property ($rose(s_axi_arready) |-> $past(s_axi_arvalid))
		else $error("read taken without valid");
	AST_RST_QUIET: assert property ($past(rst) |-> !irq && !cpu_reset_req && !core_reset_req && !system_reset_req)
		else $error("output active after reset");
	AST_BOOT_CORE: assert property ($fell(rst) && flash_boot |-> ##[1:BOOT_MAX] core_reset_req)
		else $error("no core reset after boot timeout");
	AST_BOOT_SYS: assert property ($fell(rst) && flash_boot |-> ##[1:BOOT_MAX] system_reset_req)
		else $error("no system reset after boot timeout");
	C_WR: cover property (s_axi_bvalid && s_axi_bready);
	C_IRQ: cover property ($rose(irq));
	C_CPU: cover property (cpu_reset_req);
endmodule
`default_nettype wire

/* bench/test_digital_watchdog_timers.sv */
// Purpose: Self-checking bench of the watchdog block over AXI4-Lite.
// Assumes: 200 MHz clock, short boot timeout parameter.
// Notes: Masters raise ready only after valid is seen, to stall the slave.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"
module test_digital_watchdog_timers;
	localparam int BT = 50;
	logic clock, rst, flash_boot, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] rq;
	wire [3:0] outs = {irq, rq};
	int err_count, n_tests, n;
	int cnt [3];
	digital_watchdog_timers #(.BOOT_TIMEOUT(BT)) i_dut (
		.clock(clock), .rst(rst), .flash_boot(flash_boot),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq), .cpu_reset_req(rq[0]), .core_reset_req(rq[1]), .system_reset_req(rq[2])
	);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		foreach (cnt[i]) if (rq[i] === 1'b1) cnt[i]++;
	end
	function automatic logic [7:0] ad(input logic [1:0] b, input logic [3:0] o);
		return {b, o, 2'b00};
	endfunction
	function automatic logic [31:0] cfg(input logic [3:0] en, input logic [11:0] act);
		return {15'h0, act, en, 1'b1};
	endfunction
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", s, exp, got);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		bit aw;
		bit w;
		@(posedge clock);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		k = 0;
		aw = 1'b1;
		w = 1'b1;
		// Each channel is released at the edge where its own ready is seen
		do begin
			@(posedge clock);
			k++;
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while ((aw || w) && k < 99);
		do begin @(posedge clock); k++; end while (bvalid !== 1'b1 && k < 99);
		bready <= 1'b1;
		@(posedge clock);
		bready <= 1'b0;
		chk("write handshake", k < 99, 1);
		chk("bresp", bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge clock);
		araddr <= a; arvalid <= 1'b1;
		k = 0;
		do begin @(posedge clock); k++; end while (arready !== 1'b1 && k < 99);
		arvalid <= 1'b0;
		do begin @(posedge clock); k++; end while (rvalid !== 1'b1 && k < 99);
		rready <= 1'b1;
		@(posedge clock);
		rready <= 1'b0;
		chk("read handshake", k < 99, 1);
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
	endtask
	// Cycles until output b (3 = irq) is seen high
	task automatic wait_rq(input int b, output int k);
		k = 0;
		do begin @(posedge clock); k++; end while (outs[b] !== 1'b1 && k < 400);
	endtask
	task automatic reset_dut();
		@(posedge clock);
		rst <= 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
	endtask
	task automatic clr();
		#1 cnt = '{default: 0};
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		err_count++;
		summarize();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst = 1; flash_boot = 1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf;
		awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		err_count = 0; n_tests = 0;
		reset_dut();
		rd(ad(0, 0), `WDT_BOOT_CFG_MAIN, 0);
		rd(ad(2, 0), `WDT_BOOT_CFG_AON, 0);
		rd(ad(1, 0), 0, 0);
		rd(ad(1, 8), 0, 0);
		rd(ad(3, 2), 1, 0);
		rd(ad(0, 1), BT, 0);
		wait_rq(1, n);
		chk("boot core", n < 400, 1);
		wait_rq(2, n);
		chk("boot system", n < 400, 1);
		flash_boot <= 0;
		reset_dut();
		rd(ad(0, 0), 0, 0);
		rd(ad(3, 2), 0, 0);
		wr(ad(1, 0), cfg(4'h1, 12'h003), 0);
		rd(ad(1, 0), 0, 0);
		rd(ad(1, 7), 4, 0);
		wr(ad(1, 7), 0, 2);
		wr(ad(1, 9), 0, 2);
		rd(ad(1, 9), 0, 2);
		for (int b = 0; b < 3; b++) wr(ad(b, 6), `WDT_UNLOCK_KEY, 0);
		rd(ad(1, 7), 0, 0);
		for (int s = 1; s < 5; s++) begin
			wr(ad(0, s), 12, 0);
			wr(ad(2, s), 12, 0);
		end
		wr(ad(3, 1), 1, 0);
		wr(ad(0, 0), cfg(4'hf, 12'h249), 0);
		wait_rq(3, n);
		chk("irq raised", n < 400, 1);
		wr(ad(0, 0), 0, 0);
		rd(ad(3, 0), 1, 0);
		wr(ad(3, 1), 0, 0);
		repeat (2) @(posedge clock);
		chk("irq masked", irq, 0);
		wr(ad(3, 0), 1, 0);
		rd(ad(3, 0), 0, 0);
		wr(ad(3, 1), 1, 0);
		repeat (2) @(posedge clock);
		chk("irq cleared", irq, 0);
		for (int a = 2; a < 4; a++) begin
			wr(ad(0, 0), cfg(4'hf, {4{a[2:0]}}), 0);
			wait_rq(a - 2, n);
			wait_rq(a - 2, n);
			chk("period", n, 12);
		end
		wr(ad(0, 0), cfg(4'hf, 12'h924), 0);
		clr();
		repeat (40) @(posedge clock);
		chk("main system reset", cnt[2], 0);
		wr(ad(0, 0), 0, 0);
		wr(ad(2, 0), cfg(4'hf, 12'h924), 0);
		wait_rq(2, n);
		wait_rq(2, n);
		chk("aon period", n, 12);
		wr(ad(2, 0), 0, 0);
		wr(ad(1, 1), 8, 0);
		wr(ad(1, 2), 16, 0);
		wr(ad(1, 0), cfg(4'h2, 12'h01a), 0);
		clr();
		wait_rq(1, n);
		chk("stage1 core", n < 400, 1);
		repeat (40) @(posedge clock);
		chk("stage0 off", cnt[0], 0);
		wr(ad(1, 0), 0, 0);
		wr(ad(1, 6), 0, 0);
		wr(ad(1, 0), cfg(4'h1, 12'h003), 0);
		rd(ad(1, 0), 0, 0);
		wr(ad(0, 1), 40, 0);
		wr(ad(0, 0), cfg(4'h1, 12'h002), 0);
		clr();
		repeat (6) begin
			repeat (15) @(posedge clock);
			wr(ad(0, 5), 0, 0);
		end
		chk("fed", cnt[0], 0);
		wait_rq(0, n);
		chk("after feed", n > 30 && n < 45, 1);
		summarize();
	end
endmodule
bind digital_watchdog_timers digital_watchdog_timers_properties #(.BOOT_TIMEOUT(BOOT_TIMEOUT)) i_props (.*);
`default_nettype wire
